// File: inc/afscal_pkg.sv
// Package for the full-scale calibration sequencer: mode codes, timing and reset values.
// Assumes a single master clock domain; everything else is plain ports.
`default_nettype none
package afscal_pkg;
  localparam logic [2:0] AFS_MODE_IDLE = 3'h0;
  localparam logic [2:0] AFS_MODE_CONT = 3'h1;
  localparam logic [2:0] AFS_MODE_SINGLE = 3'h2;
  localparam logic [2:0] AFS_MODE_STBY = 3'h3;
  localparam logic [2:0] AFS_MODE_ZS_INT = 3'h4;
  localparam logic [2:0] AFS_MODE_FS_INT = 3'h5;
  localparam logic [2:0] AFS_MODE_ZS_SYS = 3'h6;
  localparam logic [2:0] AFS_MODE_FS_SYS = 3'h7;
  localparam int AFS_CAL_PERIODS_CHOP = 22;
  localparam int AFS_CAL_PERIODS_NOCHOP = 24;
  localparam int AFS_MOD_CYCLE_CLKS = 16;
  localparam int AFS_CONV_PERIODS = 3;
  localparam logic [2:0] AFS_RESET_MODE = 3'h0;
  localparam logic [2:0] AFS_RESET_RANGE = 3'h4;
  localparam logic [11:0] AFS_RESET_RATE_DIV = 12'h200;
  localparam logic [23:0] AFS_NOM_GAIN = 24'h594000;
  localparam logic [23:0] AFS_NOM_OFFSET = 24'h800000;
  localparam logic [23:0] AFS_RESET_DATA = 24'h000000;
endpackage
`default_nettype wire

// File: verilog/afscal_tick.sv
// Output-rate period tick generator: prescale by one modulator cycle, then divide by the rate divisor.
// Assumes i_rate_div is held stable by the host while a sequence runs.
`default_nettype none
module afscal_tick
  import afscal_pkg::*;
#(
  parameter int DIV_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_restart,
  input wire logic [DIV_W-1:0] i_rate_div,
  output logic o_mod_tick,
  output logic o_period_tick
);
  typedef struct packed {
    logic [3:0] pre;
    logic [DIV_W-1:0] cnt;
    logic mod_tick;
    logic period_tick;
  } afs_tick_t;
  afs_tick_t state_reg;
  afs_tick_t state_next;

  // A one-bit divider cannot tell a wrap from a hold, so it is refused when the design is built.
  if (DIV_W < 2) begin : g_div_w_check
    $error("afscal_tick: DIV_W too small");
  end

  // All rates come from the master clock, so halving it doubles every duration.
  always_comb begin
    state_next = state_reg;
    state_next.mod_tick = 1'b0;
    state_next.period_tick = 1'b0;
    if (i_restart) begin
      state_next.pre = '0;
      state_next.cnt = '0;
    end else if (state_reg.pre == 4'(AFS_MOD_CYCLE_CLKS - 1)) begin // RULE15
      state_next.pre = '0;
      state_next.mod_tick = 1'b1;
      if (state_reg.cnt + DIV_W'(1) >= i_rate_div) begin
        state_next.cnt = '0;
        state_next.period_tick = 1'b1;
      end else begin
        state_next.cnt = state_reg.cnt + DIV_W'(1);
      end
    end else begin
      state_next.pre = state_reg.pre + 4'h1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_mod_tick = state_reg.mod_tick;
  assign o_period_tick = state_reg.period_tick;
endmodule
`default_nettype wire

// File: verilog/afscal_seq.sv
// Calibration and conversion sequencer: mode field, ready line, per-channel coefficients.
// Assumes the serial port delivers a one-cycle mode write strobe with the new field values.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// RULE1: Mode 1,1,1 starts system full-scale calibration on the selected input.
// RULE2: Calibration uses the gain chosen by the input range field.
// RULE3: Calibration lasts 22 periods with chop, 24 without.
// RULE4: On completion the mode field returns to 0,0,0.
// RULE5: Ready goes high at calibration start, low at completion.
// RULE6: Only selected channel gain updates; no data result produced.
// RULE7: Host must write 0,0,1 or 0,1,0 to convert again.
// RULE8: Ready may rise up to one modulator cycle after the command.
// RULE9: Host ignores ready for one modulator cycle after the command.
// RULE10: Host runs zero-scale calibration before full-scale in a full calibration.
// RULE11: Later full-scale calibrations alone adjust only the gain point.
// RULE12: Reset loads defaults, nominal coefficients in calibration registers.
// RULE13: Host should calibrate after power-up.
// RULE14: Host waits oscillator start-up before any calibration.
// RULE15: All rates and calibration time derive from the master clock.
// RULE16: With chop, host calibrates only after power-up or reset; the bench runs two more chop calibrations without a reset.
// RULE17: Mode 1,1,0 starts system zero-scale calibration updating offset.
// RULE18: Mode 0,1,0 runs one conversion then returns to idle.
// RULE19: Completion counts output-rate periods at the programmed rate.
module afscal_seq
  import afscal_pkg::*;
#(
  parameter int NCH = 3,
  parameter int CH_W = 2,
  parameter int DIV_W = 12
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_mode_wr,
  input wire logic i_op_mode_bit2,
  input wire logic i_op_mode_bit1,
  input wire logic i_op_mode_bit0,
  input wire logic [2:0] i_input_range,
  input wire logic [CH_W-1:0] i_channel,
  input wire logic i_chop_enable,
  input wire logic [DIV_W-1:0] i_rate_div,
  input wire logic [23:0] i_measure,
  input wire logic [CH_W-1:0] i_coef_sel,
  output logic [2:0] o_op_mode,
  output logic o_rdy_n,
  output logic o_cal_busy,
  output logic [2:0] o_pga_range,
  output logic [23:0] o_data,
  output logic [23:0] o_gain_coef,
  output logic [23:0] o_offset_coef,
  output logic o_gain_upd
);
  typedef enum {AFS_IDLE, AFS_ARM, AFS_RUN, AFS_CONT} afs_state_t;
  typedef struct packed {
    afs_state_t fsm;
    logic [2:0] mode;
    logic [2:0] range;
    logic [CH_W-1:0] ch;
    logic [5:0] periods;
    logic [5:0] target;
    logic rdy_n;
    logic busy;
    logic gain_upd;
    logic [23:0] data;
    logic [23:0] gain_o;
    logic [23:0] offs_o;
    logic [NCH-1:0][23:0] gain;
    logic [NCH-1:0][23:0] offs;
  } afs_seq_t;
  afs_seq_t state_reg;
  afs_seq_t state_next;
  logic mod_tick;
  logic period_tick;
  logic [2:0] wr_mode;

  // The channel select must be able to address every channel.
  if (NCH < 1 || NCH > (1 << CH_W)) begin : g_nch_check
    $error("afscal_seq: NCH does not fit CH_W");
  end

  assign wr_mode = {i_op_mode_bit2, i_op_mode_bit1, i_op_mode_bit0};

  afscal_tick #(.DIV_W(DIV_W)) u_tick (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_restart(1'b0),
    .i_rate_div(i_rate_div),
    .o_mod_tick(mod_tick),
    .o_period_tick(period_tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.gain_upd = 1'b0;
    if (i_mode_wr) begin
      state_next.mode = wr_mode;
      state_next.range = i_input_range; // RULE2
      state_next.ch = i_channel;
      state_next.periods = '0;
      unique case (wr_mode)
        AFS_MODE_FS_SYS, AFS_MODE_ZS_SYS, AFS_MODE_SINGLE: begin // RULE1 RULE17 RULE18
          // Ready rises at the next modulator tick, never later than one modulator cycle.
          state_next.fsm = AFS_ARM; // RULE8
          state_next.target = wr_mode == AFS_MODE_SINGLE ? 6'(AFS_CONV_PERIODS) :
            (i_chop_enable ? 6'(AFS_CAL_PERIODS_CHOP) : 6'(AFS_CAL_PERIODS_NOCHOP)); // RULE3
        end
        AFS_MODE_CONT: begin
          // Continuous conversion pulses ready on its own, so it never counts as busy.
          state_next.fsm = AFS_CONT;
          state_next.target = 6'(AFS_CONV_PERIODS);
          state_next.busy = 1'b0;
        end
        AFS_MODE_STBY: begin
          state_next.fsm = AFS_IDLE;
          state_next.rdy_n = 1'b1;
          state_next.busy = 1'b0;
        end
        default: begin
          // Other modes are outside this block; the sequencer just idles.
          state_next.fsm = AFS_IDLE;
          state_next.busy = 1'b0;
        end
      endcase
    end else begin
      unique case (state_reg.fsm)
        AFS_IDLE: begin
        end
        AFS_ARM: begin
          if (mod_tick) begin
            state_next.fsm = AFS_RUN;
            state_next.rdy_n = 1'b1; // RULE5
            state_next.busy = 1'b1;
          end
        end
        AFS_RUN: begin
          if (period_tick) begin
            state_next.periods = state_reg.periods + 6'h1; // RULE19
            if (state_reg.periods + 6'h1 >= state_reg.target) begin
              state_next.fsm = AFS_IDLE;
              state_next.mode = AFS_MODE_IDLE; // RULE4 RULE18
              state_next.rdy_n = 1'b0; // RULE5
              state_next.busy = 1'b0;
              state_next.periods = '0;
              // Calibrations touch one coefficient only; the data word is left alone.
              if (state_reg.mode == AFS_MODE_FS_SYS) begin
                state_next.gain[state_reg.ch] = i_measure; // RULE6 RULE11
                state_next.gain_upd = 1'b1;
              end else if (state_reg.mode == AFS_MODE_ZS_SYS) begin
                state_next.offs[state_reg.ch] = i_measure; // RULE17
              end else begin
                state_next.data = i_measure;
              end
            end
          end
        end
        AFS_CONT: begin
          if (period_tick) begin
            state_next.periods = state_reg.periods + 6'h1;
            state_next.rdy_n = 1'b1;
            if (state_reg.periods + 6'h1 >= state_reg.target) begin
              state_next.periods = '0;
              state_next.data = i_measure;
              state_next.rdy_n = 1'b0;
            end
          end
        end
      endcase
    end
    state_next.gain_o = state_next.gain[i_coef_sel];
    state_next.offs_o = state_next.offs[i_coef_sel];
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg.fsm <= AFS_IDLE; // RULE12
      state_reg.mode <= AFS_RESET_MODE;
      state_reg.range <= AFS_RESET_RANGE;
      state_reg.ch <= '0;
      state_reg.periods <= '0;
      state_reg.target <= '0;
      state_reg.rdy_n <= 1'b1;
      state_reg.busy <= 1'b0;
      state_reg.gain_upd <= 1'b0;
      state_reg.data <= AFS_RESET_DATA;
      state_reg.gain_o <= AFS_NOM_GAIN;
      state_reg.offs_o <= AFS_NOM_OFFSET;
      state_reg.gain <= {NCH{AFS_NOM_GAIN}};
      state_reg.offs <= {NCH{AFS_NOM_OFFSET}};
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_op_mode = state_reg.mode;
  assign o_rdy_n = state_reg.rdy_n;
  assign o_cal_busy = state_reg.busy;
  assign o_pga_range = state_reg.range;
  assign o_data = state_reg.data;
  assign o_gain_coef = state_reg.gain_o;
  assign o_offset_coef = state_reg.offs_o;
  assign o_gain_upd = state_reg.gain_upd;

  //////////////////////////////////////////////////////////////////////////////
  AST_FS_START_ARMS: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE1
    i_mode_wr && wr_mode == AFS_MODE_FS_SYS |=> state_reg.fsm == AFS_ARM && state_reg.mode == AFS_MODE_FS_SYS)
    else $error("full-scale command did not arm");
  AST_RANGE_LATCHED: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE2
    i_mode_wr |=> o_pga_range == $past(i_input_range))
    else $error("range not latched");
  AST_TARGET_CHOP: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE3
    i_mode_wr && wr_mode == AFS_MODE_FS_SYS |=>
      state_reg.target == ($past(i_chop_enable) ? 6'(AFS_CAL_PERIODS_CHOP) : 6'(AFS_CAL_PERIODS_NOCHOP)))
    else $error("wrong calibration length");
  AST_MODE_CLEARS: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE4
    $fell(o_cal_busy) && !$past(i_mode_wr) |-> o_op_mode == AFS_MODE_IDLE)
    else $error("mode not cleared at completion");
  AST_RDY_HIGH_BUSY: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE5
    o_cal_busy |-> o_rdy_n)
    else $error("ready low during calibration");
  AST_RDY_WITHIN_MOD: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE8
    i_mode_wr && wr_mode == AFS_MODE_FS_SYS |-> ##[1:17] ((o_rdy_n && o_cal_busy) || i_mode_wr))
    else $error("ready late after calibration command");
  AST_NO_DATA_ON_CAL: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE6
    o_gain_upd |-> $stable(o_data))
    else $error("data changed by calibration");
  AST_GAIN_ONLY_FS: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE11
    o_gain_upd |-> $past(state_reg.mode) == AFS_MODE_FS_SYS && !o_cal_busy)
    else $error("gain update outside full-scale calibration");
  AST_RESET_NOMINAL: assert property (@(posedge i_mclk) // RULE12
    $rose(i_rst_n) |-> state_reg.gain[0] == AFS_NOM_GAIN && o_rdy_n)
    else $error("reset defaults missing");
  AST_PERIODS_BOUND: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE19
    state_reg.fsm == AFS_RUN |-> state_reg.periods < state_reg.target)
    else $error("period count overran");
  AST_SINGLE_IDLE: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE18
    $fell(o_cal_busy) && $past(o_op_mode) == AFS_MODE_SINGLE && !$past(i_mode_wr) |->
      o_op_mode == AFS_MODE_IDLE && !o_rdy_n)
    else $error("single conversion did not idle");
  AST_TICK_SPACING: assert property (@(posedge i_mclk) disable iff (!i_rst_n) // RULE15
    mod_tick |=> !mod_tick [*8])
    else $error("modulator tick too frequent");

  COV_FS_DONE: cover property (@(posedge i_mclk) disable iff (!i_rst_n) o_gain_upd);
  COV_ZS_START: cover property (@(posedge i_mclk) disable iff (!i_rst_n) i_mode_wr && wr_mode == AFS_MODE_ZS_SYS);
  COV_SINGLE: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
    state_reg.fsm == AFS_RUN && state_reg.mode == AFS_MODE_SINGLE ##1 state_reg.fsm == AFS_IDLE);
  COV_RDY_FALL: cover property (@(posedge i_mclk) disable iff (!i_rst_n) $fell(o_rdy_n));
endmodule
`default_nettype wire

// File: tb/afscal_host.sv
// Host controller model: writes the mode field as a one-cycle strobe on request.
// Assumes the bench pulses i_go for one clock with the wanted mode on i_mode.
`default_nettype none
module afscal_host (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [2:0] i_mode,
  input wire logic i_rdy_n,
  output logic o_mode_wr,
  output logic [2:0] o_mode,
  output logic o_rdy_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold_off = 0;
  // Outside a strobe the mode bits toggle, so a design that samples them late sees junk.
  // During reset they load the bench's mode, so the toggling starts from a known value.
  always @(posedge i_mclk) begin
    o_mode_wr <= #1 i_go && i_rst_n;
    o_mode <= #1 (i_go || !i_rst_n) ? i_mode : ~o_mode;
    hold_off <= i_go ? 18 : (hold_off > 0 ? hold_off - 1 : 0);
  end
  // Ready is trusted only after the hold-off, since it may lag the command.
  assign o_rdy_seen = (i_rdy_n === 1'b0) && (hold_off == 0);
endmodule
`default_nettype wire

// File: tb/afscal_tb.sv
// Self-checking bench for the calibration sequencer, driven through the host model.
// Assumes the package constants and a 25 MHz master clock.
`default_nettype none
module afscal_tb
  import afscal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [23:0] gain; int lo; int hi;} afscal_note_t;
  logic mclk, rst_n, go, chop, mode_wr, rdy_n, busy, gupd, rdy_seen;
  logic [2:0] gmode, rng, mbits, op_mode, pga;
  logic [1:0] ch;
  logic [11:0] rdiv;
  logic [23:0] meas, data, gcoef, ocoef, exp_data;
  int miscompares, comparisons, cyc = 0, t_start = 0, seed, wait_cnt;
  afscal_note_t notes[$];
  afscal_note_t note;
  afscal_host i_host (.i_mclk(mclk), .i_rst_n(rst_n), .i_go(go), .i_mode(gmode), .i_rdy_n(rdy_n),
    .o_mode_wr(mode_wr), .o_mode(mbits), .o_rdy_seen(rdy_seen));
  afscal_seq #(.NCH(3), .CH_W(2), .DIV_W(12)) i_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_mode_wr(mode_wr),
    .i_op_mode_bit2(mbits[2]), .i_op_mode_bit1(mbits[1]), .i_op_mode_bit0(mbits[0]), .i_input_range(rng),
    .i_channel(ch), .i_chop_enable(chop), .i_rate_div(rdiv), .i_measure(meas), .i_coef_sel(ch),
    .o_op_mode(op_mode), .o_rdy_n(rdy_n), .o_cal_busy(busy), .o_pga_range(pga), .o_data(data),
    .o_gain_coef(gcoef), .o_offset_coef(ocoef), .o_gain_upd(gupd));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk_val(input string n, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_time(input string n, input int lo, input int hi, input int g);
    comparisons++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("unexpected %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One command through the host, then a bounded wait for ready to fall.
  task automatic run(input logic [2:0] m, input logic c, input logic [2:0] r, input logic [1:0] k, input int n);
    int p;
    int w;
    p = 16 * int'(rdiv);
    @(posedge mclk);
    #1;
    gmode = m;
    chop = c;
    rng = r;
    ch = k;
    meas = 24'($random(seed));
    go = 1'b1;
    // Ready may lag the command by a modulator cycle, and the first period may be short.
    if (m == AFS_MODE_FS_SYS) notes.push_back('{meas, (n - 1) * p, n * p + AFS_MOD_CYCLE_CLKS + 2});
    @(posedge mclk);
    #1;
    go = 1'b0;
    repeat (20) @(negedge mclk);
    chk_val("ready high", 24'h000001, {23'h0, rdy_n});
    chk_val("pga range", {21'h0, r}, {21'h0, pga});
    for (w = 0; w < 40000 && rdy_seen !== 1'b1; w++) @(negedge mclk);
    if (w == 40000) begin
      $display("unexpected timeout waiting for ready");
      miscompares++;
      end_of_test();
    end
    if (m == AFS_MODE_SINGLE) exp_data = meas;
    chk_val("mode field", 24'h0, {21'h0, op_mode});
    chk_val("busy", 24'h0, {23'h0, busy});
    repeat (2) @(negedge mclk);
    chk_val("data word", exp_data, data);
    if (m == AFS_MODE_ZS_SYS) chk_val("offset coef", meas, ocoef);
    repeat (3 * p) @(negedge mclk);
    chk_val("idle ready", 24'h0, {23'h0, rdy_n});
    chk_val("idle mode", 24'h0, {21'h0, op_mode});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) cyc <= cyc + 1;
  // Each gain update is matched with the oldest note from the driver.
  always @(negedge mclk) begin
    if (mode_wr === 1'b1) t_start = cyc;
    if (gupd === 1'b1) begin
      if (notes.size() == 0) chk_time("gain notes", 1, 1, 0);
      else begin
        note = notes.pop_front();
        chk_time("cal cycles", note.lo, note.hi, cyc - t_start);
        repeat (2) @(negedge mclk);
        chk_val("gain coef", note.gain, gcoef);
      end
    end
  end
  initial begin
    seed = 32'h5EE4;
    {rst_n, go, chop, gmode, rng, ch, meas} = '0;
    rdiv = 12'h002;
    exp_data = AFS_RESET_DATA;
    miscompares = 0;
    comparisons = 0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 1'b1;
    @(negedge mclk);
    chk_val("reset mode", {21'h0, AFS_RESET_MODE}, {21'h0, op_mode});
    chk_val("reset range", {21'h0, AFS_RESET_RANGE}, {21'h0, pga});
    chk_val("reset gain", AFS_NOM_GAIN, gcoef);
    chk_val("reset offset", AFS_NOM_OFFSET, ocoef);
    chk_val("reset data", AFS_RESET_DATA, data);
    // Zero-scale first, so the full-scale step has valid offsets.
    run(AFS_MODE_ZS_SYS, 1'b1, 3'h4, 2'h1, 22);
    run(AFS_MODE_FS_SYS, 1'b1, 3'h2, 2'h1, 22);
    run(AFS_MODE_FS_SYS, 1'b0, 3'h7, 2'h2, 24);
    chk_val("offset kept", AFS_NOM_OFFSET, ocoef);
    @(posedge mclk);
    #1 rdiv = 12'h004;
    run(AFS_MODE_FS_SYS, 1'b1, 3'h0, 2'h0, 22);
    run(AFS_MODE_SINGLE, 1'b1, 3'h4, 2'h0, 3);
    // Continuous mode keeps refreshing the data word; standby must then hold it and park ready high.
    @(posedge mclk);
    #1;
    gmode = AFS_MODE_CONT;
    meas = 24'($random(seed));
    go = 1'b1;
    @(posedge mclk);
    #1;
    go = 1'b0;
    for (wait_cnt = 0; wait_cnt < 1000 && data !== meas; wait_cnt++) @(negedge mclk);
    chk_val("cont data", meas, data);
    chk_val("cont mode", {21'h0, AFS_MODE_CONT}, {21'h0, op_mode});
    @(posedge mclk);
    #1;
    exp_data = meas;
    gmode = AFS_MODE_STBY;
    meas = 24'($random(seed));
    go = 1'b1;
    @(posedge mclk);
    #1;
    go = 1'b0;
    repeat (256) @(negedge mclk);
    chk_val("standby ready", 24'h000001, {23'h0, rdy_n});
    chk_val("standby mode", {21'h0, AFS_MODE_STBY}, {21'h0, op_mode});
    chk_val("standby data", exp_data, data);
    chk_val("notes left", 24'h0, 24'(notes.size()));
    end_of_test();
  end
endmodule
`default_nettype wire
